// ===== hdl/epiu_params.svh
`ifndef EPIU_PARAMS_SVH
`define EPIU_PARAMS_SVH

// ---------------------------------------------------------------
// encodings
// ---------------------------------------------------------------
`define EPIU_OP_ADD_PTR      8'he8
`define EPIU_OP_SUB_PTR      8'he9
`define EPIU_OP_PUSH_LIT     8'hea
`define EPIU_OP_MOVE         8'heb
`define EPIU_OP_CALL_ACC     16'h0014
`define EPIU_SECOND_NIBBLE   4'hf
`define EPIU_SEL_FRAME       2'h3
`define EPIU_FRAME_PTR_IDX   2'h2
`define EPIU_PTR_COUNT       3
`define EPIU_PTR_W           12
`define EPIU_ADDR_W          12
`define EPIU_PC_W            21
`define EPIU_PC_STEP         21'h000002
`define EPIU_ZERO_DATA       8'h00
// indirect addressing registers occupy this address range
`define EPIU_INDIRECT_LO     12'hfda
`define EPIU_INDIRECT_HI     12'hfef
`define EPIU_PTR_RESET       12'h000
`endif

// ===== hdl/epiu_pkg.sv
package epiu_pkg;
  typedef enum logic [2:0] {
    EPIU_EX_NONE,
    EPIU_EX_PTR_WRITE,
    EPIU_EX_RETURN,
    EPIU_EX_CALL,
    EPIU_EX_PUSH,
    EPIU_EX_MOVE_FIRST
  } epiu_exec_t;

  typedef struct packed {
    logic        req;
    logic [11:0] addr;
    logic [7:0]  data;
  } epiu_mem_wr_t;

  typedef struct packed {
    logic        load;
    logic [20:0] target;
  } epiu_pc_load_t;
endpackage

// ===== hdl/epiu_decode.sv
`timescale 1ns/1ps
`include "epiu_params.svh"
module epiu_decode (
  input  wire logic              [15:0] instr,     // fetched word
  input  wire logic                     ext_en,    // extension enable config
  output epiu_pkg::epiu_exec_t          kind,      // decoded class
  output logic                          is_ret,    // add/sub-and-return form
  output logic                          is_sub,    // subtract form
  output logic                   [1:0]  sel,       // pointer select
  output logic                   [7:0]  lit        // literal field
);
  always_comb begin
    kind   = epiu_pkg::EPIU_EX_NONE;
    is_ret = 1'b0;
    is_sub = 1'b0;
    sel    = instr[7:6];
    lit    = instr[7:0];
    if (ext_en) begin
      if (instr == `EPIU_OP_CALL_ACC) begin
        kind = epiu_pkg::EPIU_EX_CALL;
      end else begin
        unique case (instr[15:8])
          `EPIU_OP_ADD_PTR, `EPIU_OP_SUB_PTR: begin
            is_sub = (instr[15:8] == `EPIU_OP_SUB_PTR);
            is_ret = (instr[7:6] == `EPIU_SEL_FRAME);
            kind   = epiu_pkg::EPIU_EX_PTR_WRITE;
          end
          `EPIU_OP_PUSH_LIT: kind = epiu_pkg::EPIU_EX_PUSH;
          `EPIU_OP_MOVE:     kind = epiu_pkg::EPIU_EX_MOVE_FIRST;
          default:           kind = epiu_pkg::EPIU_EX_NONE;
        endcase
      end
    end
  end
endmodule

// ===== hdl/epiu_core.sv
`timescale 1ns/1ps
`include "epiu_params.svh"
module epiu_core (
  input  wire logic                    clock,             // core clock, 25 MHz
  input  wire logic                    reset_n,           // async reset, active low
  input  wire logic                    extension_enable_config, // programmed enable
  input  wire logic                    instr_valid,       // instr holds a new cycle's word
  input  wire logic             [15:0] instr,             // fetched instruction word
  input  wire logic             [20:0] program_counter,   // address of instr
  input  wire logic              [7:0] working_accumulator_reg, // accumulator
  input  wire logic              [7:0] pc_high_latch,     // high latch
  input  wire logic              [7:0] pc_upper_latch,    // upper latch
  input  wire logic             [20:0] return_stack_top,  // return stack top
  input  wire logic              [7:0] mem_rd_data,       // data at mem_rd_addr
  output logic                  [11:0] mem_rd_addr,       // combinational read address
  output epiu_pkg::epiu_mem_wr_t       mem_wr,            // registered data write
  output epiu_pkg::epiu_pc_load_t      pc_load,           // registered pc load
  output logic                         stack_push,        // registered push strobe
  output logic                  [20:0] stack_push_data,   // return address
  output logic                         flush_fetch,       // next cycle is idle
  output logic                         handled,           // word is an extended op or the slot after a two-cycle one
  output logic                  [11:0] file_select_pointer [3], // pointers
  output logic                  [11:0] stack_frame_pointer // alias of pointer 2
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  epiu_pkg::epiu_exec_t kind;
  logic                 is_ret;
  logic                 is_sub;
  logic [1:0]           sel;
  logic [7:0]           lit;

  epiu_decode u_decode (
    .instr  (instr),
    .ext_en (extension_enable_config),
    .kind   (kind),
    .is_ret (is_ret),
    .is_sub (is_sub),
    .sel    (sel),
    .lit    (lit)
  );

  // ---------------------------------------------------------------
  // sequencing state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EPIU_ST_IDLE,
    EPIU_ST_NOP,
    EPIU_ST_MOVE_SECOND
  } epiu_state_t;

  epiu_state_t state;
  epiu_state_t next_state;
  logic        move_indexed;
  logic        next_move_indexed;
  logic [7:0]  move_data;
  logic [7:0]  next_move_data;
  logic [11:0] ptr [3];
  logic [11:0] next_ptr [3];
  logic        next_stack_push;
  logic [20:0] next_stack_push_data;
  epiu_pkg::epiu_mem_wr_t  next_mem_wr;
  epiu_pkg::epiu_pc_load_t next_pc_load;
  logic [11:0] frame;
  logic [11:0] sum_ptr;
  logic [11:0] move_dst;
  logic        in_idle;

  assign frame   = ptr[`EPIU_FRAME_PTR_IDX];
  assign in_idle = (state == EPIU_ST_IDLE);

  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect = (a >= `EPIU_INDIRECT_LO) && (a <= `EPIU_INDIRECT_HI);
  endfunction

  // wraps modulo 4096, carry dropped on purpose
  always_comb begin
    if (is_sub) begin
      sum_ptr = ptr[is_ret ? `EPIU_FRAME_PTR_IDX : sel] - {6'h00, lit[5:0]};
    end else begin
      sum_ptr = ptr[is_ret ? `EPIU_FRAME_PTR_IDX : sel] + {6'h00, lit[5:0]};
    end
  end

  // source address; combinational so the byte returns within this cycle
  always_comb begin
    mem_rd_addr = frame + {5'h00, instr[6:0]};
  end

  always_comb begin
    if (move_indexed) begin
      move_dst = frame + {5'h00, instr[6:0]};
    end else begin
      move_dst = instr[11:0];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_move_indexed    = move_indexed;
    next_move_data       = move_data;
    next_stack_push      = 1'b0;
    next_stack_push_data = stack_push_data;
    next_mem_wr          = '0;
    next_mem_wr.addr     = mem_wr.addr;
    next_mem_wr.data     = mem_wr.data;
    next_pc_load         = '0;
    next_pc_load.target  = pc_load.target;
    for (int i = 0; i < `EPIU_PTR_COUNT; i++) begin
      next_ptr[i] = ptr[i];
    end
    if (instr_valid) begin
      unique case (state)
        EPIU_ST_IDLE: begin
          unique case (kind)
            epiu_pkg::EPIU_EX_PTR_WRITE: begin
              // flags are never touched by this block
              next_ptr[is_ret ? `EPIU_FRAME_PTR_IDX : sel] = sum_ptr;
              if (is_ret) begin
                next_pc_load.load   = 1'b1;
                next_pc_load.target = return_stack_top;
                next_state          = EPIU_ST_NOP;
              end
            end
            epiu_pkg::EPIU_EX_CALL: begin
              next_stack_push      = 1'b1;
              next_stack_push_data = program_counter + `EPIU_PC_STEP;
              next_pc_load.load    = 1'b1;
              // no accumulator, status or bank save path exists
              next_pc_load.target  = {pc_upper_latch[4:0], pc_high_latch,
                                      working_accumulator_reg};
              next_state           = EPIU_ST_NOP;
            end
            epiu_pkg::EPIU_EX_PUSH: begin
              next_mem_wr.req  = 1'b1;
              next_mem_wr.addr = frame;
              next_mem_wr.data = lit;
              next_ptr[`EPIU_FRAME_PTR_IDX] = frame - 12'h001;
            end
            epiu_pkg::EPIU_EX_MOVE_FIRST: begin
              next_move_indexed = instr[7];
              if (is_indirect(mem_rd_addr)) begin
                next_move_data = `EPIU_ZERO_DATA;
              end else begin
                next_move_data = mem_rd_data;
              end
              next_state = EPIU_ST_MOVE_SECOND;
            end
            default: begin
              // lone second word or a standard op: nothing here
              next_state = EPIU_ST_IDLE;
            end
          endcase
        end
        EPIU_ST_NOP: begin
          next_state = EPIU_ST_IDLE;
        end
        EPIU_ST_MOVE_SECOND: begin
          // a malformed second word still ends the move, without a write
          if (instr[15:12] == `EPIU_SECOND_NIBBLE &&
              !(move_indexed && is_indirect(move_dst))) begin
            next_mem_wr.req  = 1'b1;
            next_mem_wr.addr = move_dst;
            next_mem_wr.data = move_data;
          end
          next_state = EPIU_ST_IDLE;
        end
        default: next_state = EPIU_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state           <= EPIU_ST_IDLE;
      move_indexed    <= 1'b0;
      move_data       <= 8'h00;
      stack_push      <= 1'b0;
      stack_push_data <= 21'h000000;
      mem_wr          <= '0;
      pc_load         <= '0;
      for (int i = 0; i < `EPIU_PTR_COUNT; i++) begin
        ptr[i] <= `EPIU_PTR_RESET;
      end
    end else begin
      state           <= next_state;
      move_indexed    <= next_move_indexed;
      move_data       <= next_move_data;
      stack_push      <= next_stack_push;
      stack_push_data <= next_stack_push_data;
      mem_wr          <= next_mem_wr;
      pc_load         <= next_pc_load;
      for (int i = 0; i < `EPIU_PTR_COUNT; i++) begin
        ptr[i] <= next_ptr[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign flush_fetch         = in_idle && instr_valid &&
                               ((kind == epiu_pkg::EPIU_EX_PTR_WRITE && is_ret) ||
                                kind == epiu_pkg::EPIU_EX_CALL);
  assign handled             = instr_valid &&
                               (!in_idle || kind != epiu_pkg::EPIU_EX_NONE);
  assign stack_frame_pointer = ptr[`EPIU_FRAME_PTR_IDX];

  generate
    for (genvar g = 0; g < `EPIU_PTR_COUNT; g++) begin : g_ptr_out
      assign file_select_pointer[g] = ptr[g];
    end
  endgenerate
endmodule

// ===== test/epiu_chk.sv
`timescale 1ns/1ps
module epiu_chk (
  input wire logic                    clock,                   // core clock
  input wire logic                    reset_n,                 // async reset
  input wire logic                    extension_enable_config, // enable
  input wire logic                    instr_valid,             // new word
  input wire logic             [15:0] instr,                   // word
  input wire logic             [20:0] program_counter,         // word address
  input wire logic             [20:0] return_stack_top,        // stack top
  input wire logic             [11:0] mem_rd_addr,             // read address
  input epiu_pkg::epiu_mem_wr_t       mem_wr,                  // data write
  input epiu_pkg::epiu_pc_load_t      pc_load,                 // pc load
  input wire logic                    stack_push,              // push strobe
  input wire logic             [20:0] stack_push_data,         // return address
  input wire logic                    flush_fetch,             // idle next
  input wire logic                    handled,                 // consumed
  input wire logic             [11:0] file_select_pointer [3], // pointers
  input wire logic             [11:0] stack_frame_pointer      // frame pointer
);
  // ---------------------------------------------------------------
  // word tracking
  // ---------------------------------------------------------------
  logic       busy;
  logic       next_busy;
  logic       two;
  logic       fresh;
  logic [7:0] op;
  assign op = instr[15:8];
  // second words are judged apart, so a consumed word never counts as fresh
  assign two = extension_enable_config && (instr == 16'h0014 || op == 8'heb ||
               ((op == 8'he8 || op == 8'he9) && instr[7:6] == 2'h3));
  assign fresh = instr_valid && !busy && extension_enable_config;
  always_comb begin
    next_busy = busy;
    if (instr_valid) begin
      next_busy = !busy && two;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_ext_gate: assert property (!extension_enable_config |-> !handled)
    else $error("word handled while disabled");
  a_add_ptr: assert property (fresh && op == 8'he8 && instr[7:6] != 2'h3 |=>
    file_select_pointer[$past(instr[7:6])] ==
    $past(file_select_pointer[instr[7:6]]) + $past(instr[5:0])) else $error("add wrong");
  a_sub_ptr: assert property (fresh && op == 8'he9 && instr[7:6] != 2'h3 |=>
    file_select_pointer[$past(instr[7:6])] ==
    $past(file_select_pointer[instr[7:6]]) - $past(instr[5:0])) else $error("sub wrong");
  a_ret_load: assert property (fresh && instr[15:9] == 7'h74 && instr[7:6] == 2'h3 |->
    flush_fetch ##1 pc_load.load && pc_load.target == $past(return_stack_top))
    else $error("return load wrong");
  a_call_push: assert property (fresh && instr == 16'h0014 |-> flush_fetch ##1
    stack_push && stack_push_data == $past(program_counter) + 21'h2) else $error("call wrong");
  a_push_lit: assert property (fresh && op == 8'hea |=> mem_wr.req &&
    mem_wr.addr == $past(stack_frame_pointer) && mem_wr.data == $past(instr[7:0]) &&
    stack_frame_pointer == $past(stack_frame_pointer) - 12'h001) else $error("push wrong");
  a_move_read: assert property (fresh && op == 8'heb |->
    mem_rd_addr == stack_frame_pointer + instr[6:0] ##1 !mem_wr.req) else $error("move wrong");
  a_idle_word: assert property (instr_valid && busy |=> !stack_push && !pc_load.load)
    else $error("idle word acted");
  a_lone_second: assert property (fresh && instr[15:12] == 4'hf |=> !mem_wr.req)
    else $error("lone second word wrote");
  cover property (fresh && instr == 16'h0014);
  cover property (pc_load.load);
  cover property (instr_valid && busy && instr[15:12] == 4'hf);
endmodule
bind epiu_core epiu_chk chk (.*);

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  logic                    clock = 1'b0;
  logic                    reset_n = 1'b0;
  logic                    extension_enable_config = 1'b1;
  logic                    instr_valid = 1'b0;
  logic             [15:0] instr = 16'h0000;
  logic             [20:0] program_counter = 21'h001000;
  logic              [7:0] working_accumulator_reg = 8'h06;
  logic              [7:0] pc_high_latch = 8'h10;
  logic              [7:0] pc_upper_latch = 8'hff;
  logic             [20:0] return_stack_top = 21'h1a5c3e;
  logic              [7:0] mem_rd_data;
  logic             [11:0] mem_rd_addr;
  epiu_pkg::epiu_mem_wr_t  mem_wr;
  epiu_pkg::epiu_pc_load_t pc_load;
  logic                    stack_push;
  logic             [20:0] stack_push_data;
  logic                    flush_fetch;
  logic                    handled;
  logic             [11:0] file_select_pointer [3];
  logic             [11:0] stack_frame_pointer;
  logic             [11:0] ep [3];
  logic                    sf;
  logic                    sh;
  logic             [11:0] sa;
  int                      err_total = 0;
  int                      compares = 0;
  always #20 clock = ~clock;
  // memory reads nonzero except where the address low byte is EFh, so a forced 00h is visible
  assign mem_rd_data = mem_rd_addr[7:0] + 8'h11;
  epiu_core uut (.*);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // word is taken at the next edge; flush, handled and read address are sampled 2 ns after the word is driven, registered results 1 ns after the edge
  task automatic issue(input logic [15:0] w);
    instr = w;
    instr_valid = 1'b1;
    #2;
    sf = flush_fetch;
    sh = handled;
    sa = mem_rd_addr;
    @(posedge clock);
    #1;
  endtask
  task automatic ptrs();
    for (int i = 0; i < 3; i++) begin
      check("pointer", file_select_pointer[i], ep[i]);
    end
  endtask
  task automatic t_arith();
    for (int s = 0; s < 3; s++) begin
      issue({8'he8, s[1:0], 6'h3f});
      issue({8'he9, s[1:0], 6'h3f});
      issue({8'he9, s[1:0], 6'h3f});
      ep[s] = ep[s] - 12'h03f;
      ptrs();
    end
  endtask
  task automatic t_ret(input logic [7:0] op, input logic [11:0] d);
    issue({op, 8'hc5});
    check("flush", sf, 1'b1);
    check("pc load", pc_load, {1'b1, return_stack_top});
    ep[2] = ep[2] + d;
    ptrs();
    issue(16'he805);
    check("pc load", pc_load.load, 1'b0);
    ptrs();
  endtask
  task automatic t_call();
    issue(16'h0014);
    check("flush", sf, 1'b1);
    check("push", {stack_push, stack_push_data}, {1'b1, program_counter + 21'h2});
    check("pc load", pc_load,
          {1'b1, pc_upper_latch[4:0], pc_high_latch, working_accumulator_reg});
    issue(16'h0014);
    check("push", stack_push, 1'b0);
  endtask
  task automatic t_push();
    issue(16'hea08);
    check("handled", sh, 1'b1);
    check("write", mem_wr, {1'b1, ep[2], 8'h08});
    ep[2] = ep[2] - 12'h001;
    ptrs();
  endtask
  task automatic t_move(input logic [7:0] lo, input logic [15:0] w2, input logic wr,
                        input logic [11:0] dst);
    logic [11:0] src;
    logic [7:0]  dv;
    src = ep[2] + {5'h00, lo[6:0]};
    dv = (src inside {[12'hfda:12'hfef]}) ? 8'h00 : src[7:0] + 8'h11;
    issue({8'heb, lo});
    check("read addr", sa, src);
    check("early write", mem_wr.req, 1'b0);
    issue(w2);
    check("write req", mem_wr.req, wr);
    if (wr) begin
      check("write addr", mem_wr.addr, dst);
      check("write data", mem_wr.data, dv);
    end
  endtask
  task automatic t_lone();
    issue(16'hf123);
    check("write req", mem_wr.req, 1'b0);
    ptrs();
  endtask
  task automatic t_off();
    extension_enable_config = 1'b0;
    issue(16'he805);
    check("handled", sh, 1'b0);
    issue(16'h0014);
    check("push", stack_push, 1'b0);
    ptrs();
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    ep = '{default: 12'h000};
    repeat (16) @(posedge clock);
    #1;
    reset_n = 1'b1;
    ptrs();
    t_arith();
    t_ret(8'he8, 12'h005);
    t_ret(8'he9, 12'hffb);
    t_call();
    t_push();
    // destinations stay off pc low and the return stack top bytes
    t_move(8'h19, 16'hfff8, 1'b1, 12'hff8);
    t_move(8'h1a, 16'hf000, 1'b1, 12'h000);
    t_move(8'h2f, 16'hf5a5, 1'b1, 12'h5a5);
    t_move(8'h30, 16'hf123, 1'b1, 12'h123);
    t_move(8'h80, 16'hff90, 1'b1, 12'hfd0);
    t_move(8'h99, 16'hf01a, 1'b0, 12'h000);
    t_lone();
    t_off();
    print_verdict();
  end
endmodule
